/* File: include/esw_defs.vh */
// constants for the serial write port
`ifndef ESW_DEFS_VH
`define ESW_DEFS_VH
`define ESW_SYNC_STAGES 2
`define ESW_BITS_4W 4'h8
`define ESW_BITS_3W 4'h9
`define ESW_CNT_W 4
`define ESW_KIND_CMD 1'b0
`define ESW_KIND_DATA 1'b1
`define ESW_FOSC_KHZ 1000
`define ESW_CLK_MHZ 100
`define ESW_SCLK_MIN_NS 250
// clock edges the strap synchroniser needs before its output is the pin's level
`define ESW_STRAP_WAIT 2'h2
`endif

/* File: hdl/esw_sync.v */
// two-flop synchroniser for one level from outside the clock domain
module esw_sync (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // level in and out
  input wire d,
  output wire q
);
  reg meta_q;
  reg sync_q;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

/* File: hdl/esw_serial_port.v */
// write-only serial host port, 4-wire and 3-wire modes
// Notes on behaviour
// - the wire count is fixed by the static strap level and only 4-wire or 3-wire exists.
// - strap low selects 4-wire with 8-bit bytes, strap high selects 3-wire with 9-bit frames.
// - in 3-wire mode the byte-kind pin is ignored and the host holds it low.
// - the clock pin is the shift clock and the data pin is the serial input in both modes.
// - bits are taken only while the active-low select is low for the whole transfer.
// - in 4-wire mode input shifts in on each rising shift-clock edge, bit 7 first.
// - in 4-wire mode the kind pin is sampled on the eighth clock and the byte goes out then.
// - kind high means data and kind low means command.
// - the port only accepts writes and has no readback path.
// - a 3-wire frame is the kind bit then bits 7 to 0, written out on the ninth clock.
// - in 3-wire mode a leading 1 routes to display RAM and a leading 0 to commands.
`include "esw_defs.vh"
module esw_serial_port (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // strap
  input wire wire_count_strap,
  // serial pins from the host
  input wire unit_select_low_n,
  input wire serial_clk,
  input wire serial_in_line,
  input wire byte_kind,
  // byte outputs
  output reg [7:0] byte_q,
  output reg ram_write_q,
  output reg cmd_write_q,
  output wire three_wire_mode
);
  // synchronised pin levels
  wire sel_s;
  wire sclk_s;
  wire serial_in_line_s;
  wire kind_s;
  wire strap_s;
  // shift-clock edge finder
  reg sclk_prev_q;
  wire rise;
  wire take;
  // strap capture
  reg [1:0] settle_q;
  reg [1:0] settle_d;
  reg strap_taken_q;
  reg strap_taken_d;
  reg mode3_q;
  reg mode3_d;
  // frame assembly
  reg [7:0] shift_q;
  reg [7:0] shift_d;
  reg kind3_q;
  reg kind3_d;
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;
  wire [3:0] last_bit;
  wire lead_bit;
  wire frame_end;
  wire kind_now;
  // byte hand-off
  reg [7:0] byte_d;
  reg ram_write_d;
  reg cmd_write_d;

  // count sits on the leading kind bit of a 3-wire frame
  function kind_slot;
    input three;
    input [3:0] cnt;
    begin
      kind_slot = three & (cnt == 4'h0);
    end
  endfunction

  // the next accepted bit completes the frame
  function last_slot;
    input [3:0] cnt;
    input [3:0] last;
    begin
      last_slot = ((cnt + 4'h1) == last);
    end
  endfunction

  // bit count after one accepted bit, back to zero at the frame's end
  function [3:0] next_count;
    input [3:0] cnt;
    input [3:0] last;
    begin
      if (last_slot(cnt, last))
        next_count = 4'h0;
      else
        next_count = cnt + 4'h1;
    end
  endfunction

  // all host pins are asynchronous to clk; select is inverted on the way in
  // so that the synchroniser's reset value reads as deselected
  esw_sync u_sel (.clk(clk), .rst_n(rst_n), .d(~unit_select_low_n), .q(sel_s));
  esw_sync u_clk (.clk(clk), .rst_n(rst_n), .d(serial_clk), .q(sclk_s));
  esw_sync u_din (.clk(clk), .rst_n(rst_n), .d(serial_in_line), .q(serial_in_line_s));
  esw_sync u_kind (.clk(clk), .rst_n(rst_n), .d(byte_kind), .q(kind_s));
  esw_sync u_strap (.clk(clk), .rst_n(rst_n), .d(wire_count_strap), .q(strap_s));

  // data path shares the sync delay with the clock, so sampling stays aligned
  assign rise = sclk_s & ~sclk_prev_q;
  assign take = sel_s & rise;
  assign last_bit = mode3_q ? `ESW_BITS_3W : `ESW_BITS_4W;
  assign lead_bit = kind_slot(mode3_q, cnt_q);
  assign frame_end = take & last_slot(cnt_q, last_bit);
  // 3-wire takes kind from the frame's first bit, the pin is not looked at
  assign kind_now = mode3_q ? kind3_q : kind_s;
  assign three_wire_mode = mode3_q;

  // strap is read once, after the synchroniser has flushed its reset zeros;
  // a strap moved later is ignored until the next reset
  always @*
  begin
    settle_d = settle_q;
    strap_taken_d = strap_taken_q;
    mode3_d = mode3_q;
    if (settle_q != `ESW_STRAP_WAIT)
      settle_d = settle_q + 2'h1;
    else if (!strap_taken_q)
    begin
      mode3_d = strap_s;
      strap_taken_d = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settle_q <= 2'h0;
      strap_taken_q <= 1'b0;
      mode3_q <= 1'b0;
    end
    else
    begin
      settle_q <= settle_d;
      strap_taken_q <= strap_taken_d;
      mode3_q <= mode3_d;
    end
  end

  // previous level resets low, the idle level of the shift clock
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sclk_prev_q <= 1'b0;
    else
      sclk_prev_q <= sclk_s;
  end

  // bits count only while selected; a release drops a partial frame
  always @*
  begin
    shift_d = shift_q;
    kind3_d = kind3_q;
    cnt_d = cnt_q;
    if (!sel_s)
      cnt_d = 4'h0;
    else if (rise)
    begin
      if (lead_bit)
        kind3_d = serial_in_line_s;
      else
        shift_d = {shift_q[6:0], serial_in_line_s};
      cnt_d = next_count(cnt_q, last_bit);
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_q <= 8'h00;
      kind3_q <= 1'b0;
      cnt_q <= 4'h0;
    end
    else
    begin
      shift_q <= shift_d;
      kind3_q <= kind3_d;
      cnt_q <= cnt_d;
    end
  end

  // write-only: the completed byte is only ever pushed out, never read back
  always @*
  begin
    byte_d = byte_q;
    ram_write_d = 1'b0;
    cmd_write_d = 1'b0;
    if (frame_end)
    begin
      byte_d = shift_d;
      ram_write_d = (kind_now == `ESW_KIND_DATA);
      cmd_write_d = (kind_now == `ESW_KIND_CMD);
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byte_q <= 8'h00;
      ram_write_q <= 1'b0;
      cmd_write_q <= 1'b0;
    end
    else
    begin
      byte_q <= byte_d;
      ram_write_q <= ram_write_d;
      cmd_write_q <= cmd_write_d;
    end
  end
endmodule

/* File: tb/esw_serial_port_chk.sv */
// assertions for the serial port
module esw_serial_port_chk (
  // clock and reset
  input logic clk,
  input logic rst_n,
  // strap and host pins
  input logic wire_count_strap,
  input logic unit_select_low_n,
  input logic serial_clk,
  // byte outputs
  input logic [7:0] byte_q,
  input logic ram_write_q,
  input logic cmd_write_q,
  input logic three_wire_mode
);
  timeunit 1ns / 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire r = ram_write_q, c = cmd_write_q, m = three_wire_mode, p = r | c;
  sequence quiet; $stable(serial_clk) [*8]; endsequence
  sequence idle; unit_select_low_n [*8]; endsequence
  a_one_kind: assert property (!(r && c)) else $error("kind");
  a_ram_once: assert property (r |=> !r) else $error("ram");
  a_cmd_once: assert property (c |=> !c) else $error("cmd");
  a_byte_cause: assert property (!$stable(byte_q) |-> p) else $error("byte");
  a_sel_gate: assert property (idle |=> !p) else $error("sel");
  a_clk_gate: assert property (quiet |=> !p) else $error("clk");
  // mode is latched on the third edge after release and holds from then on
  a_mode_fix: assert property ($past(rst_n, 4) |-> $stable(m)) else $error("mode");
  a_mode_pin: assert property ($past(rst_n, 3) |-> m == wire_count_strap) else $error("pin");
endmodule
bind esw_serial_port esw_serial_port_chk u_chk (
  .clk(clk),
  .rst_n(rst_n),
  .wire_count_strap(wire_count_strap),
  .unit_select_low_n(unit_select_low_n),
  .serial_clk(serial_clk),
  .byte_q(byte_q),
  .ram_write_q(ram_write_q),
  .cmd_write_q(cmd_write_q),
  .three_wire_mode(three_wire_mode)
);

/* File: tb/esw_host.sv */
// host model writing serial frames
module esw_host (
  // host pins toward the port
  output logic unit_select_low_n,
  output logic serial_clk,
  output logic serial_in_line,
  output logic byte_kind
);
  timeunit 1ns / 100ps;
  // idle levels: deselected, shift clock low
  initial
  begin
    unit_select_low_n = 1'b1;
    serial_clk = 1'b0;
    serial_in_line = 1'b0;
    byte_kind = 1'b0;
  end
  // one frame of n bits; m picks 3-wire, v[8] is the byte kind
  task automatic frame(input logic m, input logic [8:0] v, input int n);
    int i;
    i = m ? 8 : 7;
    unit_select_low_n <= 1'b0;
    repeat (n)
    begin
      serial_in_line <= v[i];
      byte_kind <= !m & v[8];
      i--;
      #62.5 serial_clk <= 1'b1;
      #62.5 serial_clk <= 1'b0;
    end
    #62.5 unit_select_low_n <= 1'b1;
    // a released line flips so that a late sample shows up as a bad bit
    serial_in_line <= ~serial_in_line;
    #250;
  endtask
endmodule

/* File: tb/esw_serial_port_tb.sv */
// bench for the serial port
module esw_serial_port_tb;
  timeunit 1ns / 1ns;
  logic clk = 0;
  logic rst_n = 0;
  logic wire_count_strap = 0;
  logic ram_write_q;
  logic cmd_write_q;
  logic three_wire_mode;
  logic unit_select_low_n;
  logic serial_clk;
  logic serial_in_line;
  logic byte_kind;
  logic [7:0] byte_q;
  logic [15:0] lf = 16'h8919;
  logic [8:0] want;
  logic [8:0] q[$];
  int n_fail;
  int compares;
  esw_host h (
    .unit_select_low_n(unit_select_low_n),
    .serial_clk(serial_clk),
    .serial_in_line(serial_in_line),
    .byte_kind(byte_kind)
  );
  esw_serial_port u_dut (
    .clk(clk),
    .rst_n(rst_n),
    .wire_count_strap(wire_count_strap),
    .unit_select_low_n(unit_select_low_n),
    .serial_clk(serial_clk),
    .serial_in_line(serial_in_line),
    .byte_kind(byte_kind),
    .byte_q(byte_q),
    .ram_write_q(ram_write_q),
    .cmd_write_q(cmd_write_q),
    .three_wire_mode(three_wire_mode)
  );
  initial forever #5 clk = ~clk;
  function automatic logic [15:0] nx(logic [15:0] s);
    return {s[14:0], ^(s & 16'hb400)};
  endfunction
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  // pulses stand from one rising edge to the next, so look half way
  always @(negedge clk)
    if ((ram_write_q | cmd_write_q) !== 1'b0)
    begin
      want = q.size() > 0 ? q.pop_front() : ~{ram_write_q, byte_q};
      chk({ram_write_q, byte_q}, want);
      chk({8'h00, cmd_write_q}, {8'h00, ~want[8]});
    end
  task automatic run(input logic m);
    @(posedge clk);
    wire_count_strap <= m;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // the strap is latched on the third edge after release
    repeat (4) @(posedge clk);
    chk({8'h00, three_wire_mode}, {8'h00, m});
    for (int i = 0; i < 8; i++)
    begin
      lf = nx(lf);
      if (i != 3)
        q.push_back(lf[8:0]);
      h.frame(m, lf[8:0], i == 3 ? 5 : 8 + m);
    end
    #500;
    chk(9'(q.size()), 9'h0);
    chk({8'h00, three_wire_mode}, {8'h00, m});
    $display("done %0d", m);
  endtask
  task automatic conclude(int f);
    n_fail += f;
    $display("%0d compares %0d n_fail", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial #100us conclude(1);
  initial
  begin
    run(0);
    run(1);
    conclude(0);
  end
endmodule
